// ---- ioss_switch.sv ----
// sequence selector, timing control and sequence switches with apb access
module ioss_switch (
  input  wire logic                          pclk,
  input  wire logic                          presetn,
  input  wire logic [7:0]                    paddr,
  input  wire logic                          psel,
  input  wire logic                          penable,
  input  wire logic                          pwrite,
  input  wire logic [31:0]                   pwdata,
  output logic      [31:0]                   prdata,
  output logic                               pready,
  output logic                               pslverr,
  input  wire logic [ioss_pkg::NSEQ-1:0]     unit_done,
  input  wire logic [ioss_pkg::NSEQ-1:0]     unit_fault,
  input  wire logic [ioss_pkg::NSEQ-1:0]     unit_maint,
  input  wire logic [ioss_pkg::NSEQ*ioss_pkg::BW-1:0] input_data_bus,
  output logic                               sync_pulse,
  output logic                               unit_stop,
  output logic      [ioss_pkg::NSEQ-1:0]     unit_preset,
  output logic      [ioss_pkg::NSEQ*ioss_pkg::BW-1:0] unit_buffer,
  output logic      [ioss_pkg::NSEQ-1:0]     mode_select_pulse,
  output logic                               select_level,
  output logic      [ioss_pkg::NSEQ-1:0]     disconnect_level,
  output logic      [ioss_pkg::NSEQ-1:0]     active_sequence_select,
  output logic      [ioss_pkg::NSEQ-1:0]     control_sequence_select,
  output logic      [5:0]                    unit_status_levels,
  output logic                               ctl_to_xchg,
  output logic                               buf_to_xchg
);
  import ioss_pkg::*;

  typedef struct packed {
    ioss_state_t           st;
    logic [4:0]            pk;
    logic [4:0]            qk;
    logic [4:0]            delay_sync_counter;
    logic                  qk_on;
    logic                  eb;
    logic                  eb_req;
    logic                  tsd_pend;
    logic                  ios_pend;
    logic [2:0]            ios_type;
    logic [1:0]            ios_seq;
    logic [2:0]            ios_mode;
    logic [1:0]            ai;
    logic [XW-1:0]         xr;
    logic [NSEQ-1:0]       flag;
    logic [NSEQ-1:0]       act;
    logic [NSEQ-1:0]       nd;
    logic [NSEQ-1:0]       d1;
    logic [NSEQ-1:0]       d2;
    logic [NSEQ-1:0]       d3;
    logic [NSEQ-1:0]       f1;
    logic [NSEQ-1:0]       f2;
    logic [NSEQ-1:0]       m1;
    logic [NSEQ-1:0]       m2;
    logic [NSEQ*BW-1:0]    ib1;
    logic [NSEQ*BW-1:0]    ib2;
    logic [NSEQ*BW-1:0]    ubuf;
    ioss_unit_t [NSEQ-1:0] u;
    logic                  sync;
    logic                  stop;
    logic [NSEQ-1:0]       preset;
    logic [NSEQ-1:0]       msel;
    logic                  sel_lvl;
    logic [NSEQ-1:0]       disc;
    logic [5:0]            stat;
    logic                  ctl_x;
    logic                  buf_x;
    logic                  pready;
    logic                  pslverr;
    logic [31:0]           prdata;
  } ioss_st_t;

  ioss_st_t        q;
  ioss_st_t        n;
  logic [NSEQ-1:0] done;

  // status levels that sequence i reports
  function automatic logic [5:0] status_of(input ioss_unit_t uu, input logic mt,
                                           input int i);
    logic [5:0] s;
    s = '0;
    if (HAS_SWITCH[i]) begin
      s[S_BUSY]   = ~uu.conn | ~uu.ready | (MAINT_BUSY[i] & mt);
      s[S_MISSED] = FREE_RUN[i] & IS_INPUT[i] & uu.conn & uu.missed & ~mt;
      s[S_FAULT]  = HAS_FAULT[i] & ~mt & uu.conn & uu.fault;
      s[S_NORMAL] = MULTI_MODE[i] ? ~uu.asm_mode : FIXED_NORM[i];
      s[S_RIGHT]  = ~uu.reverse_direction_flag;
      s[S_IN]     = MULTI_UNIT[i] ? uu.in_dir : IS_INPUT[i];
    end
    return s;
  endfunction

  // exchange position of buffer bit b
  function automatic int xpos(input int i, input logic asm_on, input int b);
    int p;
    p = b;
    if (asm_on) begin
      p = NINE_BIT[i] ? 4 * b : 6 * b;
    end
    return p;
  endfunction

  function automatic int width_of(input int i);
    return NINE_BIT[i] ? 9 : 6;
  endfunction

  function automatic logic [2:0] pick(input logic [NSEQ-1:0] req);
    logic [2:0] r;
    r = '0;
    for (int i = 0; i < NSEQ; i++) begin
      if (req[i]) begin
        r = {1'b1, 2'(i)};
      end
    end
    return r;
  endfunction

  ioss_sync_if sif [NSEQ] ();

  generate
    for (genvar g = 0; g < NSEQ; g++) begin : g_unit
      assign sif[g].sync_en  = q.sync;
      assign sif[g].event_in = q.d2[g] & ~q.d3[g];
      assign done[g]         = sif[g].done;
      ioss_sync u_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .s       (sif[g])
      );
    end
  endgenerate

  always_comb begin
    logic        wr;
    logic [2:0]  pk_sel;
    logic [5:0]  act_st;
    int          a;
    int          j;
    ioss_unit_t  uu;
    logic [5:0]  ev_st;
    wr     = psel & penable & q.pready & pwrite;
    // any raised flag competes; a completion only raises one on a connected unit
    pk_sel = pick(q.flag);
    a      = int'(q.ai);
    act_st = status_of(q.u[a], q.m2[a], a);
    j      = 0;
    uu     = '0;
    ev_st  = '0;
    n = q;
    n.sync   = 1'b0;
    n.msel   = '0;
    n.disc   = '0;
    n.preset = '0;
    n.pready = 1'b0;
    n.pslverr = 1'b0;
    // pins cross in through two flops
    n.d1  = unit_done;
    n.d2  = q.d1;
    n.d3  = q.d2;
    n.f1  = unit_fault;
    n.f2  = q.f1;
    n.m1  = unit_maint;
    n.m2  = q.m1;
    n.ib1 = input_data_bus;
    n.ib2 = q.ib1;

    // register access, answered one cycle after setup
    if (psel && !penable) begin
      n.pready = 1'b1;
      n.prdata = '0;
      case (paddr)
        A_XLO:    n.prdata = q.xr[31:0];
        A_XHI:    n.prdata = {28'h0000000, q.xr[XW-1:32]};
        A_IOS:    n.prdata = {23'h000000, q.ios_pend, q.ios_mode, q.ios_seq, q.ios_type};
        A_TSD:    n.prdata = {28'h0000000, q.tsd_pend, q.qk_on, q.eb, q.eb_req};
        A_STAT:   n.prdata = {10'h000, q.st, q.buf_x, q.ctl_x, q.stat, q.flag,
                              q.nd, q.act};
        A_PRESET: n.prdata = {31'h00000000, q.stop};
        A_UNIT:   n.prdata = q.u;
        default:  n.pslverr = 1'b1;
      endcase
    end
    if (wr) begin
      case (paddr)
        A_XLO: n.xr[31:0] = pwdata;
        A_XHI: n.xr[XW-1:32] = pwdata[3:0];
        A_IOS: begin
          n.ios_pend = 1'b1;
          n.ios_type = pwdata[2:0];
          n.ios_seq  = pwdata[4:3];
          n.ios_mode = pwdata[7:5];
          n.nd       = NSEQ'(1) << pwdata[4:3];
        end
        A_TSD: begin
          n.tsd_pend = 1'b1;
          n.eb_req   = pwdata[0];
        end
        A_PRESET: begin
          n.stop = pwdata[1];
          if (pwdata[0]) begin
            for (int i = 0; i < NSEQ; i++) begin
              if (!q.m2[i]) begin
                n.preset[i] = 1'b1;
                n.u[i]       = '0;
                n.u[i].ready = ~IS_INPUT[i];
                n.u[i].in_dir = IS_INPUT[i];
                n.stop       = 1'b1;
              end
            end
          end
        end
        default: ;
      endcase
    end

    // instruction and delay cycles
    case (q.st)
      ST_PK: begin
        n.pk = (q.pk == PK_LAST) ? 5'h00 : q.pk + 5'h01;
        if ((q.pk == PK_SYNC_A || q.pk == PK_SYNC_B) && !q.qk_on) begin
          n.sync = 1'b1;
        end
        if (q.pk == PK_LAST) begin
          if (q.tsd_pend && !q.qk_on) begin
            if (act_st[S_BUSY]) begin
              n.st  = ST_DSK;
              n.delay_sync_counter = 5'h00;
            end else begin
              n.qk_on    = 1'b1;
              n.qk       = 5'h00;
              n.eb       = q.eb_req;
              n.tsd_pend = 1'b0;
            end
          end else if (!q.qk_on && !q.tsd_pend && pk_sel[2]) begin
            n.ai  = pk_sel[1:0];
            n.act = NSEQ'(1) << pk_sel[1:0];
          end
        end
      end
      ST_DSK: begin
        n.delay_sync_counter = q.delay_sync_counter + 5'h01;
        // pulse at count CSK_SYNC while the active unit is still busy
        if (q.delay_sync_counter == CSK_SYNC && act_st[S_BUSY]) begin
          n.sync = 1'b1;
        end
        if (q.delay_sync_counter == CSK_LAST) begin
          n.delay_sync_counter = 5'h00;
          if (!act_st[S_BUSY]) begin
            n.st = ST_PK;
            n.pk = 5'h00;
          end
        end
      end
      default: begin
        n.st = ST_PK;
        n.pk = 5'h00;
      end
    endcase

    // operand cycle of a transfer on the active sequence
    if (q.qk_on) begin
      n.qk = q.qk + 5'h01;
      uu = q.u[a];
      if (q.eb) begin
        // direction via status: in_dir control flop on MULTI_UNIT sequences, IS_INPUT wiring otherwise
        if (!act_st[S_IN]) begin
          if (q.qk == QK_CLR) begin
            n.ubuf[a*BW +: BW] = '0;
          end
          if (q.qk == QK_SET) begin
            for (int b = 0; b < BW; b++) begin
              j = xpos(a, uu.asm_mode, b);
              if (b < width_of(a) && q.xr[j]) begin
                n.ubuf[a*BW + b] = 1'b1;
              end
            end
          end
        end else if (q.qk == QK_SET) begin
          for (int b = 0; b < BW; b++) begin
            j = xpos(a, uu.asm_mode, b);
            if (b < width_of(a)) begin
              n.xr[j] = q.ubuf[a*BW + b];
            end
          end
        end
      end
      if (q.qk == QK_LAST) begin
        n.qk_on      = 1'b0;
        n.u[a].ready = 1'b0;
        n.flag[a]    = 1'b0;
      end
    end

    // control instruction at its time slot
    if (q.st == ST_PK && q.pk == PK_IOS && q.ios_pend) begin
      j = int'(q.ios_seq);
      n.ios_pend = 1'b0;
      n.nd       = '0;
      if (q.ios_type == IOS_LOWER) begin
        n.flag[j] = 1'b0;
      end else if (q.ios_type == IOS_RAISE) begin
        n.flag[j] = 1'b1;
      end else if (!q.m2[j] && HAS_SWITCH[j]) begin
        if (q.ios_type == IOS_MODE || q.ios_type == IOS_SEL) begin
          n.msel[j] = 1'b1;
          n.sel_lvl = (q.ios_type == IOS_SEL);
          if (!q.u[j].conn) begin
            n.u[j].conn  = 1'b1;
            n.u[j].ready = ~IS_INPUT[j];
          end
          if (q.ios_type == IOS_SEL && MULTI_UNIT[j]) begin
            n.u[j].sub = q.ios_mode[0];
          end else begin
            n.u[j].asm_mode = MULTI_MODE[j] & q.ios_mode[0];
            n.u[j].reverse_direction_flag      = q.ios_mode[1];
            if (MULTI_UNIT[j]) begin
              n.u[j].in_dir = q.ios_mode[2];
            end
          end
        end else if (q.ios_type == IOS_DISC) begin
          n.disc[j]   = 1'b1;
          n.u[j].conn = 1'b0;
        end
      end
    end

    // hardware events last so a same-cycle set beats a clear
    for (int i = 0; i < NSEQ; i++) begin
      if (q.f2[i] && HAS_FAULT[i]) begin
        n.u[i].fault = 1'b1;
      end
      if (done[i] && q.u[i].conn) begin
        n.flag[i] = 1'b1;
        ev_st = status_of(q.u[i], q.m2[i], i);
        if (ev_st[S_IN]) begin
          if (q.u[i].ready && FREE_RUN[i]) begin
            n.u[i].missed = 1'b1;
          end
          n.ubuf[i*BW +: BW] = q.ib2[i*BW +: BW];
        end
        n.u[i].ready = 1'b1;
      end
    end

    n.stat  = act_st;
    n.ctl_x = ~(q.qk_on & q.eb);
    n.buf_x = q.qk_on & q.eb;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q        <= '0;
      q.st     <= ST_PK;
      q.ctl_x  <= 1'b1;
      q.stat   <= 6'h00;
      for (int i = 0; i < NSEQ; i++) begin
        q.u[i].ready  <= ~IS_INPUT[i];
        q.u[i].in_dir <= IS_INPUT[i];
      end
      q.stop   <= 1'b1;
      q.act    <= 4'h1;
    end else begin
      q <= n;
    end
  end

  // sync and stop reach every switch
  assign sync_pulse              = q.sync;
  assign unit_stop               = q.stop;
  assign unit_preset             = q.preset;
  assign unit_buffer             = q.ubuf;
  assign mode_select_pulse       = q.msel;
  assign select_level            = q.sel_lvl;
  assign disconnect_level        = q.disc;
  assign active_sequence_select  = q.act;
  assign control_sequence_select = q.nd;
  assign unit_status_levels      = q.stat;
  assign ctl_to_xchg             = q.ctl_x;
  assign buf_to_xchg             = q.buf_x;
  assign prdata                  = q.prdata;
  assign pready                  = q.pready;
  assign pslverr                 = q.pslverr;
endmodule

// ---- ioss_pkg.sv ----
// constants, types and register map of the sequence switch block
package ioss_pkg;
  localparam int NSEQ = 4;
  localparam int XW   = 36;
  localparam int BW   = 9;

  localparam logic [7:0] A_XLO    = 8'h00;
  localparam logic [7:0] A_XHI    = 8'h04;
  localparam logic [7:0] A_IOS    = 8'h08;
  localparam logic [7:0] A_TSD    = 8'h0C;
  localparam logic [7:0] A_STAT   = 8'h10;
  localparam logic [7:0] A_PRESET = 8'h14;
  localparam logic [7:0] A_UNIT   = 8'h18;

  // per-sequence wiring, bit i belongs to sequence i
  localparam logic [NSEQ-1:0] HAS_SWITCH = 4'h7;
  localparam logic [NSEQ-1:0] IS_INPUT   = 4'h5;
  localparam logic [NSEQ-1:0] HAS_FAULT  = 4'h3;
  localparam logic [NSEQ-1:0] FREE_RUN   = 4'h2;
  localparam logic [NSEQ-1:0] MULTI_MODE = 4'h6;
  localparam logic [NSEQ-1:0] MULTI_UNIT = 4'h2;
  localparam logic [NSEQ-1:0] NINE_BIT   = 4'h6;
  localparam logic [NSEQ-1:0] MAINT_BUSY = 4'h1;
  localparam logic [NSEQ-1:0] FIXED_NORM = 4'h1;

  localparam logic [4:0] PK_LAST   = 5'h0F;
  localparam logic [4:0] PK_SYNC_A = 5'h01;
  localparam logic [4:0] PK_SYNC_B = 5'h0C;
  localparam logic [4:0] PK_IOS    = 5'h0D;
  localparam logic [4:0] QK_LAST   = 5'h17;
  localparam logic [4:0] QK_CLR    = 5'h12;
  localparam logic [4:0] QK_SET    = 5'h14;
  localparam logic [4:0] CSK_LAST  = 5'h0F;
  localparam logic [4:0] CSK_SYNC  = 5'h0B;

  localparam logic [2:0] IOS_DISC  = 3'h2;
  localparam logic [2:0] IOS_MODE  = 3'h3;
  localparam logic [2:0] IOS_LOWER = 3'h4;
  localparam logic [2:0] IOS_RAISE = 3'h5;
  localparam logic [2:0] IOS_SEL   = 3'h6;

  // status level positions
  localparam int S_BUSY   = 0;
  localparam int S_MISSED = 1;
  localparam int S_FAULT  = 2;
  localparam int S_NORMAL = 3;
  localparam int S_RIGHT  = 4;
  localparam int S_IN     = 5;

  typedef enum logic [1:0] {
    ST_PK  = 2'b01,
    ST_DSK = 2'b10
  } ioss_state_t;

  typedef struct packed {
    logic conn;
    logic ready;
    logic fault;
    logic missed;
    logic asm_mode;
    logic reverse_direction_flag;
    logic in_dir;
    logic sub;
  } ioss_unit_t;
endpackage

// ---- ioss_sync_if.sv ----
// per-unit link between the switch and its completion synchroniser
interface ioss_sync_if;
  logic sync_en;
  logic event_in;
  logic done;
  modport link (input sync_en, input event_in, output done);
  modport ctl  (output sync_en, output event_in, input done);
endinterface

// ---- ioss_sync.sv ----
// completion synchroniser stepped by the sync pulses
module ioss_sync (
  input wire logic   pclk,
  input wire logic   presetn,
  ioss_sync_if.link  s
);
  typedef struct packed {
    logic pend;
    logic s1;
    logic s2;
  } ioss_sy_t;

  ioss_sy_t q;
  ioss_sy_t n;

  // s1 and s2 only move on a sync pulse; an event sets pend in any cycle
  always_comb begin
    n = q;
    if (s.sync_en) begin
      n.s1 = q.pend;
      n.s2 = q.s1;
      if (q.s2) begin
        n.pend = 1'b0;
        n.s1   = 1'b0;
        n.s2   = 1'b0;
      end
    end
    if (s.event_in) begin
      n.pend = 1'b1;
    end
  end

  assign s.done = s.sync_en & q.s2;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end
endmodule

// ---- ioss_properties.sv ----
// port-level checks of the sequence switch
module ioss_properties (
  input wire logic       pclk,
  input wire logic       presetn,
  input wire logic       psel,
  input wire logic       penable,
  input wire logic       pready,
  input wire logic       pslverr,
  input wire logic       sync_pulse,
  input wire logic [3:0] unit_preset,
  input wire logic [3:0] mode_select_pulse,
  input wire logic [3:0] disconnect_level,
  input wire logic [3:0] active_sequence_select,
  input wire logic [5:0] unit_status_levels,
  input wire logic       ctl_to_xchg,
  input wire logic       buf_to_xchg
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_answer;
    pready ##1 !pready;
  endsequence
  a_apb_answer: assert property (s_setup |=> s_answer)
    else $error("apb answer not one cycle after setup");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("error flag without ready");
  a_xchg_exclusive: assert property (ctl_to_xchg != buf_to_xchg)
    else $error("exchange gating levels not complementary");
  a_active_onehot: assert property ($onehot(active_sequence_select))
    else $error("active select not one-hot");
  a_sync_gap: assert property (sync_pulse |=> !sync_pulse [*4])
    else $error("sync pulses too close");
  a_mode_pulse: assert property (|mode_select_pulse |->
    disconnect_level == 4'h0 ##1 mode_select_pulse == 4'h0)
    else $error("mode pulse malformed");
  a_disc_pulse: assert property (|disconnect_level |->
    $onehot(disconnect_level) ##1 disconnect_level == 4'h0)
    else $error("disconnect pulse malformed");
  a_noswitch_quiet: assert property (
    active_sequence_select[3] && $past(active_sequence_select[3]) |-> unit_status_levels == 6'h00)
    else $error("status active without a switch");
  a_preset_pulse: assert property (|unit_preset |=> unit_preset == 4'h0)
    else $error("preset longer than one cycle");
endmodule

bind ioss_switch ioss_properties u_props (
  .pclk, .presetn, .psel, .penable, .pready, .pslverr, .sync_pulse, .unit_preset,
  .mode_select_pulse, .disconnect_level, .active_sequence_select, .unit_status_levels,
  .ctl_to_xchg, .buf_to_xchg
);

// ---- ioss_unit_model.sv ----
// behavioural peripheral units: completion some cycles after a kick
module ioss_unit_model (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [3:0]  kick,
  input  wire logic [35:0] dat,
  output logic      [3:0]  unit_done,
  output logic      [35:0] input_data_bus
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] cnt_q [4];
  // done stays up longer than the pin synchroniser so no event is lost
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      input_data_bus <= '0;
      for (int i = 0; i < 4; i++) cnt_q[i] <= 4'h0;
    end else begin
      if (|kick) input_data_bus <= dat;
      for (int i = 0; i < 4; i++)
        cnt_q[i] <= kick[i] ? 4'hC : (cnt_q[i] != 4'h0 ? cnt_q[i] - 4'h1 : 4'h0);
    end
  end
  always_comb for (int i = 0; i < 4; i++) unit_done[i] = cnt_q[i] inside {[4'h1:4'h8]};
endmodule

// ---- io_sequence_switch_control_tb.sv ----
// self-checking bench for the sequence switch
module io_sequence_switch_control_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import ioss_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, e, bx;
  logic        sync_pulse, unit_stop, select_level, ctl_to_xchg, buf_to_xchg;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, r;
  logic [3:0]  unit_done, unit_fault, unit_maint, kick, ms, dl, pr, unit_preset;
  logic [3:0]  mode_select_pulse, disconnect_level, active_sequence_select;
  logic [3:0]  control_sequence_select;
  logic [5:0]  unit_status_levels;
  logic [35:0] input_data_bus, unit_buffer, dat, x, y;
  int          fail_count, tests_run, sp;
  logic [2:0]  tl [8] = '{3'h3, 3'h2, 3'h0, 3'h1, 3'h4, 3'h7, 3'h6, 3'h5};

  ioss_switch dut (
    .pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr,
    .unit_done, .unit_fault, .unit_maint, .input_data_bus, .sync_pulse, .unit_stop,
    .unit_preset, .unit_buffer, .mode_select_pulse, .select_level, .disconnect_level,
    .active_sequence_select, .control_sequence_select, .unit_status_levels,
    .ctl_to_xchg, .buf_to_xchg
  );
  ioss_unit_model um (.pclk, .presetn, .kick, .dat, .unit_done, .input_data_bus);

  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  task automatic chk(input logic [35:0] g, input logic [35:0] w, input string m);
    tests_run++;
    if (g !== w) begin
      fail_count++;
      $display("[ERR] %0t %s got %h want %h", $time, m, g, w);
    end
  endtask

  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge pclk);
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    psel <= 1'b1;
    penable <= 1'b0;
    @(posedge pclk);
    penable <= 1'b1;
    // no cycle limit here: only the watchdog ends a hung access
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic watch(input int n);
    ms = '0;
    dl = '0;
    pr = '0;
    bx = 1'b0;
    sp = 0;
    repeat (n) begin
      @(posedge pclk);
      ms |= mode_select_pulse;
      dl |= disconnect_level;
      pr |= unit_preset;
      bx |= buf_to_xchg;
      sp += int'(sync_pulse);
    end
  endtask

  task automatic io_control_instr(input logic [2:0] m, input logic [1:0] s, input logic [2:0] t);
    apb(A_IOS, 1'b1, {24'h0, m, s, t});
    @(posedge pclk);
    chk(36'(control_sequence_select), 36'(4'h1 << s), "control select");
    watch(40);
  endtask

  task automatic transfer_data_instr();
    x = 36'({$urandom, $urandom});
    apb(A_XLO, 1'b1, x[31:0]);
    apb(A_XHI, 1'b1, {28'h0, x[35:32]});
    apb(A_TSD, 1'b1, 32'h1);
    watch(80);
  endtask

  task automatic wait_act(input logic [3:0] v);
    int n;
    n = 0;
    while (active_sequence_select !== v && n < 300) begin
      @(posedge pclk);
      n++;
    end
    chk(36'(active_sequence_select), 36'(v), "active seq");
  endtask

  // nine-bit unit: buffer bit b from exchange bit b, or 4b when splayed
  function automatic logic [8:0] spread(input logic [35:0] v, input logic asm);
    for (int b = 0; b < 9; b++) spread[b] = asm ? v[4*b] : v[b];
  endfunction

  task automatic final_report();
    $display("tests_run=%0d fail_count=%0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  initial begin
    #2000000;
    fail_count++;
    $display("[ERR] %0t watchdog expired", $time);
    final_report();
  end

  initial begin
    void'($urandom(32'h96d3ffeb));
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    unit_fault = 4'h0;
    unit_maint = 4'h0;
    kick = 4'h0;
    dat = 36'h0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk(36'({unit_stop, ctl_to_xchg, buf_to_xchg, active_sequence_select}), 36'h61, "reset");
    apb(A_UNIT, 1'b0, 32'h0);
    chk(36'(r), 36'h40024002, "unit reset");
    apb(8'h1C, 1'b0, 32'h0);
    chk(36'({e, r}), 36'h100000000, "unmapped");
    foreach (tl[i]) begin
      io_control_instr(3'h0, 2'h1, tl[i]);
      chk(36'({ms[1], dl[1]}), 36'({tl[i] == 3'h3 || tl[i] == 3'h6, tl[i] == 3'h2}), "ios");
      if (ms[1] === 1'b1) chk(36'(select_level), 36'(tl[i] == 3'h6), "select");
      apb(A_UNIT, 1'b0, 32'h0);
      if (i < 4) chk(36'(r[15]), 36'(tl[i] == 3'h3), "connect");
    end
    wait_act(4'h2);
    io_control_instr(3'h0, 2'h1, 3'h3);
    unit_fault <= 4'h2;
    watch(8);
    chk(36'(unit_status_levels), 36'(6'b011100), "status");
    unit_fault <= 4'h0;
    transfer_data_instr();
    chk(36'(bx), 36'h1, "operand gating");
    chk(36'(unit_buffer[17:9]), 36'(spread(x, 1'b0)), "normal out");
    chk(36'(unit_status_levels[0]), 36'h1, "busy");
    kick <= 4'h2;
    @(posedge pclk);
    kick <= 4'h0;
    watch(60);
    chk(36'(unit_status_levels[0]), 36'h0, "ready again");
    io_control_instr(3'h3, 2'h1, 3'h3);
    chk(36'(unit_status_levels[4:3]), 36'h0, "asm reverse");
    transfer_data_instr();
    chk(36'(unit_buffer[17:9]), 36'(spread(x, 1'b1)), "assembly out");
    io_control_instr(3'h0, 2'h2, 3'h3);
    dat <= 36'({$urandom, $urandom});
    kick <= 4'h7;
    @(posedge pclk);
    kick <= 4'h0;
    wait_act(4'h4);
    watch(4);
    chk(36'(unit_buffer[26:18]), 36'(dat[26:18]), "input load");
    chk(36'(unit_buffer[8:0]), 36'h0, "unconnected");
    chk(36'(unit_status_levels[5]), 36'h1, "input status");
    // keep sequence 2 active: drop the competing flag first
    io_control_instr(3'h0, 2'h1, 3'h4);
    transfer_data_instr();
    apb(A_XHI, 1'b0, 32'h0);
    y[35:32] = r[3:0];
    apb(A_XLO, 1'b0, 32'h0);
    chk({y[35:32], r}, {x[35:9], dat[26:18]}, "input xfer");
    // unit now busy, so the next transfer waits in delay cycles
    apb(A_TSD, 1'b1, 32'h1);
    watch(20);
    watch(32);
    chk(36'(sp), 36'd2, "delay pulses");
    apb(A_STAT, 1'b0, 32'h0);
    chk(36'(r[21:20]), 36'h2, "delay state");
    dat <= 36'({$urandom, $urandom});
    kick <= 4'h4;
    @(posedge pclk);
    kick <= 4'h0;
    watch(150);
    apb(A_XLO, 1'b0, 32'h0);
    chk(36'(r[8:0]), 36'(dat[26:18]), "delayed xfer");
    unit_maint <= 4'h4;
    io_control_instr(3'h0, 2'h2, 3'h3);
    chk(36'(ms[2]), 36'h0, "maint refuse");
    apb(A_PRESET, 1'b1, 32'h1);
    watch(40);
    chk(36'(pr), 36'hB, "preset gating");
    apb(A_UNIT, 1'b0, 32'h0);
    chk(36'(r & 32'hF0F0F0F0), 36'h40804000, "preset state");
    unit_maint <= 4'h0;
    io_control_instr(3'h0, 2'h3, 3'h5);
    wait_act(4'h8);
    watch(3);
    chk(36'(unit_status_levels), 36'h0, "no switch");
    watch(160);
    chk(36'(sp), 36'd20, "sync count");
    final_report();
  end
endmodule
